// ### design/capture_consts.svh
`ifndef CAPTURE_CONSTS_SVH
`define CAPTURE_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFF_CTRL      8'h00
`define OFF_COUNT     8'h04
`define OFF_RSTPOS    8'h08
`define OFF_CMPAMT    8'h0c
`define OFF_CMPCTL    8'h10
`define OFF_CMPREM    8'h14
`define OFF_LASTCAP   8'h18
`define OFF_AXIS      8'h1c
`define OFF_IRQSTAT   8'h20
`define OFF_IRQMASK   8'h24

// ------------------------------------------------------------
// control word fields
// ------------------------------------------------------------
`define F_START       0
`define F_PRESET      1
`define F_CHAIN       2
`define F_LAUNCH      3
`define F_SRC_LSB     4
`define F_POL_LSB     8
`define F_TIME_LSB    12
`define SRC_OFF       4'h0
`define SRC_AUX       4'h1
`define SRC_PULSE     4'h2
`define SRC_MOTOR     4'h3
`define POL_NC        4'h1

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define CTRL_RST      16'h2010
`define CTRL_MAX      16'hf13f
`define COUNT_RST     16'h0001
`define CMPAMT_RST    16'h0001
`define PATH_FIFTY    8'h32

// ------------------------------------------------------------
// interrupt status bits
// ------------------------------------------------------------
`define IRQ_CAPTURE   0
`define IRQ_DONE      1
`define IRQ_REFUSED   2
`define IRQ_LAUNCH    3
`define IRQ_W         4

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TRIG_UNIT_NS  1000000
`define CLK_PERIOD_NS 10

`endif

// ### design/capture_pkg.sv
package capture_pkg;
	typedef enum logic {CAP_IDLE, CAP_RUN} cap_state_t;
endpackage : capture_pkg

// ### design/position_capture_control.sv
`timescale 1ns/100ps
`include "capture_consts.svh"
module position_capture_control
	import capture_pkg::*;
#(
	parameter int MS_CYCLES = `TRIG_UNIT_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// position sources and trigger
	input  wire logic [31:0] aux_pos,
	input  wire logic [31:0] pulse_cmd_pos,
	input  wire logic [31:0] motor_pos,
	input  wire logic        trig_pin,
	// capture results
	output logic             capture_done_output,
	output logic             capture_valid,
	output logic [31:0]      capture_data,
	output logic             pos_load,
	output logic [31:0]      pos_load_value,
	output logic             compare_enable,
	output logic             path_launch,
	output logic [7:0]       path_number,
	output logic             irq
);
	cap_state_t      state_q, state_d;
	logic [15:0]     ctrl_q, ctrl_d, cnt_q, cnt_d, cmp_amt_q, cmp_amt_d, cmp_rem_q, cmp_rem_d;
	logic [31:0]     rst_pos_q, rst_pos_d, last_q, last_d, axis_q, axis_d, hrdata_q, hrdata_d;
	logic [`IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d, ev;
	logic            done_q, done_d, first_q, first_d, cmp_en_q, cmp_en_d;
	logic            valid_q, valid_d, pload_q, pload_d, launch_q, launch_d, irq_q, irq_d;
	logic [7:0]      pnum_q, pnum_d, wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
	logic            wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d, ready_q, ready_d;
	logic            trig, cap_ev, addr_ok;
	logic [31:0]     sel_pos;
	logic [15:0]     wdata;

	function automatic logic [3:0] ctrl_src(input logic [15:0] c);
		ctrl_src = c[`F_SRC_LSB +: 4];
	endfunction : ctrl_src

	function automatic logic wr_hit(input logic p, input logic [7:0] a, input logic [7:0] o);
		wr_hit = p && (a == o);
	endfunction : wr_hit

	trigger_filter #(
		.MS_CYCLES (MS_CYCLES)
	) u_trig (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.trig_pin   (trig_pin),
		.polarity   (ctrl_q[`F_POL_LSB +: 4]),
		.trig_ms    (ctrl_q[`F_TIME_LSB +: 4]),
		.trig_pulse (trig)
	);

	// ------------------------------------------------------------
	// source select
	// ------------------------------------------------------------
	always_comb begin
		unique case (ctrl_src(ctrl_q))
			`SRC_AUX:   sel_pos = aux_pos;
			`SRC_PULSE: sel_pos = pulse_cmd_pos;
			`SRC_MOTOR: sel_pos = motor_pos;
			default:    sel_pos = axis_q;
		endcase
	end

	// ------------------------------------------------------------
	// bus front end
	// ------------------------------------------------------------
	// reads take one wait state so a write just before is visible
	always_comb begin
		addr_ok   = hsel && htrans[1] && hready;
		wr_pend_d = addr_ok && hwrite;
		rd_pend_d = addr_ok && !hwrite;
		wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
		rd_addr_d = addr_ok ? haddr[7:0] : rd_addr_q;
		ready_d   = !rd_pend_d;
		hrdata_d  = hrdata_q;
		if (rd_pend_q) begin
			unique case (rd_addr_q)
				`OFF_CTRL:    hrdata_d = {16'h0000, ctrl_q};
				`OFF_COUNT:   hrdata_d = {16'h0000, cnt_q};
				`OFF_RSTPOS:  hrdata_d = rst_pos_q;
				`OFF_CMPAMT:  hrdata_d = {16'h0000, cmp_amt_q};
				`OFF_CMPCTL:  hrdata_d = {31'h00000000, cmp_en_q};
				`OFF_CMPREM:  hrdata_d = {16'h0000, cmp_rem_q};
				`OFF_LASTCAP: hrdata_d = last_q;
				`OFF_AXIS:    hrdata_d = axis_q;
				`OFF_IRQSTAT: hrdata_d = {28'h0000000, stat_q};
				`OFF_IRQMASK: hrdata_d = {28'h0000000, mask_q};
				default:      hrdata_d = 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// capture control
	// ------------------------------------------------------------
	always_comb begin
		wdata     = hwdata[15:0];
		state_d   = state_q;
		ctrl_d    = ctrl_q;
		cnt_d     = cnt_q;
		cmp_amt_d = cmp_amt_q;
		cmp_rem_d = cmp_rem_q;
		cmp_en_d  = cmp_en_q;
		rst_pos_d = rst_pos_q;
		last_d    = last_q;
		done_d    = done_q;
		first_d   = first_q;
		valid_d   = 1'b0;
		pload_d   = 1'b0;
		launch_d  = 1'b0;
		pnum_d    = pnum_q;
		mask_d    = mask_q;
		ev        = '0;
		axis_d    = (ctrl_src(ctrl_q) != `SRC_OFF) ? sel_pos : axis_q;
		if (wr_hit(wr_pend_q, wr_addr_q, `OFF_CTRL) && wdata <= `CTRL_MAX) begin
			if (ctrl_q[`F_START]) begin
				// a second start is dropped; only a stop is taken
				if (!wdata[`F_START]) begin
					ctrl_d  = wdata;
					state_d = CAP_IDLE;
				end
			end else if (wdata[`F_START] && cnt_q != 16'h0000) begin
				ctrl_d  = wdata;
				state_d = CAP_RUN;
				done_d  = 1'b0;
				first_d = 1'b1;
			end else if (wdata[`F_START]) begin
				ctrl_d = wdata & ~16'h0001;
				done_d = 1'b0;
				ev[`IRQ_REFUSED] = 1'b1;
			end else begin
				ctrl_d = wdata;
			end
		end
		// count and reset position writes are only taken while stopped
		if (state_q == CAP_IDLE) begin
			if (wr_hit(wr_pend_q, wr_addr_q, `OFF_COUNT)) begin
				cnt_d = wdata;
			end
			if (wr_hit(wr_pend_q, wr_addr_q, `OFF_RSTPOS)) begin
				rst_pos_d = hwdata;
			end
		end
		if (wr_hit(wr_pend_q, wr_addr_q, `OFF_CMPAMT) && !cmp_en_q) begin
			cmp_amt_d = wdata;
		end
		if (wr_hit(wr_pend_q, wr_addr_q, `OFF_CMPCTL)) begin
			cmp_en_d = hwdata[0];
			if (hwdata[0] && !cmp_en_q) begin
				cmp_rem_d = cmp_amt_q;
			end
		end
		if (wr_hit(wr_pend_q, wr_addr_q, `OFF_IRQMASK)) begin
			mask_d = hwdata[`IRQ_W-1:0];
		end
		cap_ev = trig && state_q == CAP_RUN && state_d == CAP_RUN
			&& ctrl_src(ctrl_q) != `SRC_OFF;
		if (cap_ev) begin
			last_d  = sel_pos;
			valid_d = 1'b1;
			cnt_d   = cnt_q - 16'h0001;
			first_d = 1'b0;
			ev[`IRQ_CAPTURE] = 1'b1;
			if (first_q && ctrl_q[`F_PRESET]) begin
				pload_d = 1'b1;
			end
			if (first_q && ctrl_q[`F_CHAIN] && !cmp_en_q) begin
				cmp_en_d  = 1'b1;
				cmp_rem_d = cmp_amt_q;
			end
			if (cnt_q == 16'h0001) begin
				state_d = CAP_IDLE;
				done_d  = 1'b1;
				ctrl_d[`F_START] = 1'b0;
				ev[`IRQ_DONE] = 1'b1;
				if (ctrl_q[`F_LAUNCH]) begin
					launch_d = 1'b1;
					pnum_d   = `PATH_FIFTY;
					ev[`IRQ_LAUNCH] = 1'b1;
				end
			end
		end
		// new events win over a same-cycle write-one clear
		stat_d = stat_q | ev;
		if (wr_hit(wr_pend_q, wr_addr_q, `OFF_IRQSTAT)) begin
			stat_d = (stat_q & ~hwdata[`IRQ_W-1:0]) | ev;
		end
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q   <= CAP_IDLE;
			ctrl_q    <= `CTRL_RST;
			cnt_q     <= `COUNT_RST;
			cmp_amt_q <= `CMPAMT_RST;
			cmp_rem_q <= 16'h0000;
			cmp_en_q  <= 1'b0;
			rst_pos_q <= 32'h00000000;
			last_q    <= 32'h00000000;
			axis_q    <= 32'h00000000;
			done_q    <= 1'b0;
			first_q   <= 1'b0;
			valid_q   <= 1'b0;
			pload_q   <= 1'b0;
			launch_q  <= 1'b0;
			pnum_q    <= 8'h00;
			stat_q    <= '0;
			mask_q    <= '0;
			irq_q     <= 1'b0;
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rd_addr_q <= 8'h00;
			ready_q   <= 1'b1;
			hrdata_q  <= 32'h00000000;
		end else begin
			state_q   <= state_d;
			ctrl_q    <= ctrl_d;
			cnt_q     <= cnt_d;
			cmp_amt_q <= cmp_amt_d;
			cmp_rem_q <= cmp_rem_d;
			cmp_en_q  <= cmp_en_d;
			rst_pos_q <= rst_pos_d;
			last_q    <= last_d;
			axis_q    <= axis_d;
			done_q    <= done_d;
			first_q   <= first_d;
			valid_q   <= valid_d;
			pload_q   <= pload_d;
			launch_q  <= launch_d;
			pnum_q    <= pnum_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			irq_q     <= irq_d;
			wr_pend_q <= wr_pend_d;
			rd_pend_q <= rd_pend_d;
			wr_addr_q <= wr_addr_d;
			rd_addr_q <= rd_addr_d;
			ready_q   <= ready_d;
			hrdata_q  <= hrdata_d;
		end
	end

	assign hrdata              = hrdata_q;
	assign hreadyout           = ready_q;
	assign hresp               = 1'b0;
	assign capture_done_output = done_q;
	assign capture_valid       = valid_q;
	assign capture_data        = last_q;
	assign pos_load            = pload_q;
	assign pos_load_value      = rst_pos_q;
	assign compare_enable      = cmp_en_q;
	assign path_launch         = launch_q;
	assign path_number         = pnum_q;
	assign irq                 = irq_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic start_wr, ctrl_wr_ok;
	assign ctrl_wr_ok = wr_hit(wr_pend_q, wr_addr_q, `OFF_CTRL) && wdata <= `CTRL_MAX;
	assign start_wr   = ctrl_wr_ok && wdata[`F_START] && !ctrl_q[`F_START];

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	start_clears_done_a: assert property (
		start_wr && cnt_q != 16'h0000 |=> state_q == CAP_RUN && !capture_done_output
	) else $error("accepted start did not clear done");
	count_step_a: assert property (
		cap_ev |=> cnt_q == $past(cnt_q) - 16'h0001 && capture_valid
	) else $error("capture did not decrement count");
	finish_a: assert property (
		cap_ev && cnt_q == 16'h0001 |=> capture_done_output && !ctrl_q[`F_START]
			&& state_q == CAP_IDLE
	) else $error("finish did not set done and clear start");
	refuse_a: assert property (
		start_wr && cnt_q == 16'h0000 |=> !ctrl_q[`F_START] && !capture_done_output
			&& state_q == CAP_IDLE
	) else $error("start at zero count was not refused");
	no_restart_a: assert property (
		ctrl_wr_ok && ctrl_q[`F_START] && wdata[`F_START] && !cap_ev |=> $stable(ctrl_q)
	) else $error("second start write was taken");
	preset_a: assert property (
		cap_ev && first_q && ctrl_q[`F_PRESET] |=> pos_load ##1 !pos_load
	) else $error("position reset missing after first capture");
	chain_a: assert property (
		cap_ev && first_q && ctrl_q[`F_CHAIN] && !cmp_en_q
			|=> compare_enable && cmp_rem_q == $past(cmp_amt_q)
	) else $error("chained compare not enabled");
	chain_skip_a: assert property (
		cap_ev && first_q && cmp_en_q && !wr_pend_q |=> $stable(cmp_rem_q)
	) else $error("chain touched running compare");
	launch_a: assert property (
		cap_ev && cnt_q == 16'h0001 && ctrl_q[`F_LAUNCH]
			|=> path_launch && path_number == `PATH_FIFTY
	) else $error("path fifty not launched");
	src_off_a: assert property (
		ctrl_src(ctrl_q) == `SRC_OFF |=> !capture_valid
	) else $error("capture with source off");
	ctrl_range_a: assert property (
		ctrl_q <= `CTRL_MAX
	) else $error("control word out of range");
	motor_axis_a: assert property (
		ctrl_src(ctrl_q) == `SRC_MOTOR |=> axis_q == $past(motor_pos)
	) else $error("axis not following motor encoder");
	// done only falls on a start write, accepted or refused
	done_hold_a: assert property (
		capture_done_output && !start_wr |=> capture_done_output
	) else $error("done dropped without a start write");
	done_flag_a: assert property (
		cap_ev && cnt_q == 16'h0001 |=> stat_q[`IRQ_DONE]
	) else $error("finish did not flag done");
	refuse_flag_a: assert property (
		start_wr && cnt_q == 16'h0000 |=> stat_q[`IRQ_REFUSED]
	) else $error("refused start not flagged");
	idle_quiet_a: assert property (
		state_q == CAP_IDLE |=> !capture_valid
	) else $error("capture while stopped");

	start_c:  cover property (start_wr ##[1:50] cap_ev);
	finish_c: cover property (cap_ev && cnt_q == 16'h0001);
	chain_c:  cover property (cap_ev && first_q && ctrl_q[`F_CHAIN] && !cmp_en_q);
	refuse_c: cover property (start_wr && cnt_q == 16'h0000);
	launch_c: cover property (path_launch);
endmodule : position_capture_control

// ### design/trigger_filter.sv
`timescale 1ns/100ps
`include "capture_consts.svh"
module trigger_filter #(
	parameter int MS_CYCLES = 100000
) (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// trigger contact and settings
	input  wire logic       trig_pin,
	input  wire logic [3:0] polarity,
	input  wire logic [3:0] trig_ms,
	// qualified trigger
	output logic            trig_pulse
);
	logic        sync1_q, sync2_q, act_prev_q, pulse_q, pulse_d, act;
	logic [16:0] ms_cnt_q, ms_cnt_d;
	logic [3:0]  hold_q, hold_d;

	// ------------------------------------------------------------
	// contact sense and lockout
	// ------------------------------------------------------------
	always_comb begin
		act      = (polarity == `POL_NC) ? ~sync2_q : sync2_q;
		pulse_d  = 1'b0;
		hold_d   = hold_q;
		ms_cnt_d = ms_cnt_q;
		if (act && !act_prev_q && hold_q == 4'h0) begin
			pulse_d  = 1'b1;
			hold_d   = trig_ms;
			ms_cnt_d = 17'h00000;
		end else if (hold_q != 4'h0) begin
			// lockout counts whole milliseconds after each trigger
			if (ms_cnt_q == 17'(MS_CYCLES - 1)) begin
				ms_cnt_d = 17'h00000;
				hold_d   = hold_q - 4'h1;
			end else begin
				ms_cnt_d = ms_cnt_q + 17'h00001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_q    <= 1'b0;
			sync2_q    <= 1'b0;
			act_prev_q <= 1'b0;
			pulse_q    <= 1'b0;
			hold_q     <= 4'h0;
			ms_cnt_q   <= 17'h00000;
		end else begin
			sync1_q    <= trig_pin;
			sync2_q    <= sync1_q;
			act_prev_q <= act;
			pulse_q    <= pulse_d;
			hold_q     <= hold_d;
			ms_cnt_q   <= ms_cnt_d;
		end
	end

	assign trig_pulse = pulse_q;
endmodule : trigger_filter

// ### dv/tb_top.sv
`timescale 1ns/100ps
`include "capture_consts.svh"
module tb_top;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel    = 1'b0;
	logic [31:0] haddr   = 32'h0;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic [31:0] hwdata  = 32'h0;
	logic        fire    = 1'b0;
	logic        nc      = 1'b0;
	logic [31:0] aux_v   = 32'h0;
	logic [31:0] pulse_v = 32'h0;
	logic [31:0] motor_v = 32'h0;
	logic [31:0] hrdata, capture_data, pos_load_value, aux_pos, pulse_cmd_pos, motor_pos;
	logic        hreadyout, hresp, trig_pin, capture_done_output, capture_valid;
	logic        pos_load, compare_enable, path_launch, irq;
	logic [7:0]  path_number;
	logic [31:0] exp_q[$];
	logic [31:0] rpos;
	integer      seed = 32'h0ee1609c;
	int          fail_count = 0;
	int          comparisons = 0;
	int          launches = 0;

	always #5 hclk = ~hclk;

	position_capture_control #(.MS_CYCLES(10)) u_position_capture_control (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .aux_pos(aux_pos),
		.pulse_cmd_pos(pulse_cmd_pos), .motor_pos(motor_pos), .trig_pin(trig_pin),
		.capture_done_output(capture_done_output), .capture_valid(capture_valid),
		.capture_data(capture_data), .pos_load(pos_load), .pos_load_value(pos_load_value),
		.compare_enable(compare_enable), .path_launch(path_launch),
		.path_number(path_number), .irq(irq));

	trig_source_model u_trig_source_model (
		.hclk(hclk), .hresetn(hresetn), .fire(fire), .nc_contact(nc),
		.aux_set(aux_v), .pulse_set(pulse_v), .motor_set(motor_v), .aux_pos(aux_pos),
		.pulse_cmd_pos(pulse_cmd_pos), .motor_pos(motor_pos), .trig_pin(trig_pin));

	// --------------------------------
	// checking and bus tasks
	// --------------------------------
	task results;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one wait for hready, bounded so a stuck slave ends the run
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			results();
		end
	endtask : wait_ready

	task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_ready();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		r = hrdata;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		chk(r, exp);
		chk(hresp, 32'h0);
	endtask : rd_chk

	// leading contact edge is judged well before the trailing one can land
	task fire_wait;
		fire <= 1'b1;
		@(posedge hclk);
		fire <= 1'b0;
		repeat (8) @(posedge hclk);
	endtask : fire_wait

	// --------------------------------
	// output monitor
	// --------------------------------
	always @(posedge hclk) begin
		if (capture_valid === 1'b1) begin
			chk(exp_q.size(), 32'h1);
			if (exp_q.size() > 0) begin
				chk(capture_data, exp_q.pop_front());
			end
		end
		if (pos_load === 1'b1) begin
			chk(pos_load_value, rpos);
		end
		if (path_launch === 1'b1) begin
			chk({24'h0, path_number}, 32'h32);
			launches++;
		end
	end

	// --------------------------------
	// scenarios
	// --------------------------------
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(`OFF_CTRL, 32'h2010);
		rd_chk(`OFF_COUNT, 32'h1);
		rd_chk(8'h40, 32'h0);
		// run to completion with every function bit set
		rpos = $random(seed);
		aux_v <= $random(seed);
		wr(`OFF_IRQMASK, 32'h2);
		wr(`OFF_RSTPOS, rpos);
		wr(`OFF_CMPAMT, 32'h3);
		wr(`OFF_COUNT, 32'h2);
		wr(`OFF_CTRL, 32'h001f);
		wr(`OFF_CTRL, 32'h001d);
		rd_chk(`OFF_CTRL, 32'h001f);
		exp_q.push_back(aux_v);
		fire_wait();
		chk(exp_q.size(), 32'h0);
		rd_chk(`OFF_COUNT, 32'h1);
		chk(compare_enable, 32'h1);
		rd_chk(`OFF_CMPREM, 32'h3);
		exp_q.push_back(aux_v);
		fire_wait();
		chk(capture_done_output, 32'h1);
		rd_chk(`OFF_CTRL, 32'h001e);
		chk(launches, 32'h1);
		chk(irq, 32'h1);
		wr(`OFF_IRQSTAT, 32'hf);
		// irq is registered at the write's own edge; look one edge later
		@(posedge hclk);
		chk(irq, 32'h0);
		// every source under both contact senses
		for (int s = 0; s < 4; s++) begin
			for (int p = 0; p < 2; p++) begin
				nc <= p[0];
				aux_v <= $random(seed);
				pulse_v <= $random(seed);
				motor_v <= $random(seed);
				repeat (4) @(posedge hclk);
				wr(`OFF_COUNT, 32'h2);
				wr(`OFF_CTRL, {20'h0, p[3:0], s[3:0], 4'h1});
				@(posedge hclk);
				chk(capture_done_output, 32'h0);
				if (s != 0) begin
					exp_q.push_back(s == 1 ? aux_v : (s == 2 ? pulse_v : motor_v));
				end
				fire_wait();
				chk(exp_q.size(), 32'h0);
				repeat (6) @(posedge hclk);
				rd_chk(`OFF_COUNT, s == 0 ? 32'h2 : 32'h1);
				if (s == 3) begin
					rd_chk(`OFF_AXIS, motor_v);
				end
				wr(`OFF_CTRL, 32'h0);
			end
		end
		// a second closure inside the one millisecond lockout is ignored
		nc <= 1'b0;
		repeat (4) @(posedge hclk);
		wr(`OFF_COUNT, 32'h2);
		wr(`OFF_CTRL, 32'h1015);
		exp_q.push_back(aux_v);
		fire_wait();
		fire_wait();
		rd_chk(`OFF_COUNT, 32'h1);
		rd_chk(`OFF_CMPREM, 32'h3);
		repeat (20) @(posedge hclk);
		exp_q.push_back(aux_v);
		fire_wait();
		chk(capture_done_output, 32'h1);
		// start with nothing left to capture
		wr(`OFF_IRQSTAT, 32'hf);
		wr(`OFF_COUNT, 32'h0);
		wr(`OFF_CTRL, 32'h0011);
		rd_chk(`OFF_CTRL, 32'h0010);
		chk(capture_done_output, 32'h0);
		rd_chk(`OFF_IRQSTAT, 32'h4);
		chk(irq, 32'h0);
		wr(`OFF_IRQMASK, 32'h4);
		@(posedge hclk);
		chk(irq, 32'h1);
		// control word range
		wr(`OFF_CTRL, 32'hf140);
		rd_chk(`OFF_CTRL, 32'h0010);
		wr(`OFF_CTRL, 32'hf13e);
		rd_chk(`OFF_CTRL, 32'hf13e);
		chk(exp_q.size(), 32'h0);
		results();
	end
endmodule : tb_top

// ### dv/trig_source_model.sv
`timescale 1ns/100ps
// --------------------------------
// position sources and trigger contact
// --------------------------------
module trig_source_model (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// stimulus from the bench
	input  wire logic        fire,
	input  wire logic        nc_contact,
	input  wire logic [31:0] aux_set,
	input  wire logic [31:0] pulse_set,
	input  wire logic [31:0] motor_set,
	// toward the capture block
	output logic [31:0]      aux_pos,
	output logic [31:0]      pulse_cmd_pos,
	output logic [31:0]      motor_pos,
	output logic             trig_pin
);
	logic [1:0] hold_q;

	// closure held three cycles so it survives the sync stages
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_q <= 2'h0;
		end else if (fire) begin
			hold_q <= 2'h3;
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	// a closed contact reads high when normally open, low when normally closed
	assign trig_pin = (hold_q != 2'h0) ^ nc_contact;

	always_ff @(posedge hclk) begin
		aux_pos       <= aux_set;
		pulse_cmd_pos <= pulse_set;
		motor_pos     <= motor_set;
	end
endmodule : trig_source_model
